// File: core/qss_pkg.sv
// qss_pkg: widths, bit positions, select codes and reset values of the status block
// assumes: shared by the status core and its error queue, one clock domain
package qss_pkg;

   // register widths
   localparam int STB_W  = 8;
   localparam int ESR_W  = 8;
   localparam int SCPI_W = 16;
   localparam int ERR_W  = 16;

   // questionable condition bit positions
   localparam int QB_PROBE_SUPPLY = 1;
   localparam int QB_PROBE        = 2;
   localparam int QB_CHANNEL      = 3;
   localparam int QB_TEMP         = 4;
   localparam int QB_CONVERTER    = 5;
   localparam int QB_GENERATOR    = 6;
   localparam int QB_UNCAL        = 8;
   localparam int QB_LIMIT        = 9;
   localparam int QB_MARGIN       = 10;
   localparam int QB_LOW_AMPL     = 11;
   localparam int QB_LOOP_LOCK    = 13;
   localparam int QUES_PINS       = 11;

   // status byte bit positions
   localparam int STB_ERRQ = 2;
   localparam int STB_QUES = 3;
   localparam int STB_MAV  = 4;
   localparam int STB_ESB  = 5;
   localparam int STB_RQS  = 6;
   localparam int STB_OPER = 7;
   localparam logic [7:0] STB_SRQ_MASK = 8'hBC;

   // event status register
   localparam int ESR_POWER_ON = 7;
   localparam logic [7:0] ESR_RESET = 8'h80;

   // reset and preset values
   localparam logic [15:0] SCPI_ZERO = 16'h0000;
   localparam logic [15:0] SCPI_ONES = 16'hFFFF;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;

   // register select codes; scpi register r field f sits at r*SEL_FIELDS+f
   localparam int SEL_W      = 4;
   localparam int SEL_FIELDS = 5;
   localparam int F_COND     = 0;
   localparam int F_EVENT    = 1;
   localparam int F_ENABLE   = 2;
   localparam int F_PTR      = 3;
   localparam int F_NTR      = 4;
   localparam int NUM_SCPI   = 2;
   localparam int REG_OPER   = 0;
   localparam int REG_QUES   = 1;
   localparam logic [3:0] SEL_ESR = 4'hA;
   localparam logic [3:0] SEL_ESE = 4'hB;
   localparam logic [3:0] SEL_SRE = 4'hC;
   localparam logic [3:0] SEL_STB = 4'hD;

   // error queue
   localparam int ERRQ_DEPTH = 8;
   localparam logic [15:0] ERR_NONE = 16'h0000;

endpackage

// File: core/qss_err_queue.sv
// qss_err_queue: error queue memory, first in first out, registered read data
// assumes: push and pop are one-cycle pulses on clk; clear empties it at once
`timescale 1ns/1ps
module qss_err_queue import qss_pkg::*; #(
   parameter int WIDTH = ERR_W,
   parameter int DEPTH = ERRQ_DEPTH
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // control
   input  wire logic             clear,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   // read side
   output logic      [WIDTH-1:0] dout_q,
   output logic                  dout_valid_q,
   output logic                  empty,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             do_push;
   logic             do_pop;

   assign empty   = (count_q == '0);
   assign full    = (count_q == (AW+1)'(DEPTH));
   // overflow drops the newest entry so older causes stay readable
   assign do_push = push & ~full & ~clear;
   assign do_pop  = pop & ~empty & ~clear;

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr_q] <= push_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // pop on empty answers the no-error code
   always_ff @(posedge clk) begin
      if (rst) begin
         dout_q       <= ERR_NONE;
         dout_valid_q <= 1'b0;
      end else begin
         dout_valid_q <= pop;
         dout_q       <= do_pop ? mem[rd_ptr_q] : ERR_NONE;
      end
   end

   a_err_push_count: assert property (@(posedge clk) disable iff (rst)
      (push && !full && !clear && !pop) |=> (count_q == $past(count_q) + 1'b1))
      else $error("error entry not added to queue");

endmodule

// File: core/qss_status_core.sv
// qss_status_core: questionable/operation registers, event status, status byte, service request
// assumes: command strobes are one-cycle pulses from the same clock; condition pins are async
`timescale 1ns/1ps
module qss_status_core import qss_pkg::*; #(
   parameter int ERR_DEPTH = ERRQ_DEPTH
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // questionable condition pins
   input  wire logic              probe_supply_overload,
   input  wire logic              probe_overload,
   input  wire logic              channel_overload,
   input  wire logic              temperature_fault,
   input  wire logic              converter_clipping,
   input  wire logic              generator_overload,
   input  wire logic              uncalibrated_flag,
   input  wire logic              limit_exceeded,
   input  wire logic              margin_exceeded,
   input  wire logic              low_amplitude_flag,
   input  wire logic              loop_lock_lost,
   // operation condition pins
   input  wire logic [SCPI_W-1:0] oper_cond_in,
   // event status sources and output buffer state
   input  wire logic [ESR_W-1:0]  esr_event_set,
   input  wire logic              out_buf_avail,
   // error reporting
   input  wire logic              err_push,
   input  wire logic [ERR_W-1:0]  err_code,
   input  wire logic              err_pop,
   output logic      [ERR_W-1:0]  err_rd_code_q,
   output logic                   err_rd_valid_q,
   // register access
   input  wire logic [SEL_W-1:0]  reg_sel,
   input  wire logic              wr_en,
   input  wire logic [SCPI_W-1:0] wr_data,
   input  wire logic              rd_en,
   output logic      [SCPI_W-1:0] rd_data_q,
   output logic                   rd_valid_q,
   // commands
   input  wire logic              cmd_device_clear,
   input  wire logic              cmd_reset,
   input  wire logic              cmd_status_preset,
   input  wire logic              cmd_clear_status,
   input  wire logic              msg_terminator,
   input  wire logic              cmd_start,
   // results
   output logic                   srq_q,
   output logic                   flush_out_q,
   output logic                   flush_in_q,
   output logic                   abort_cmd_q,
   output logic                   settings_reset_q
);

   logic [QUES_PINS-1:0] pin_meta_q;
   logic [QUES_PINS-1:0] pin_q;
   logic [SCPI_W-1:0]    oper_meta_q;
   logic [SCPI_W-1:0]    oper_q;
   logic [SCPI_W-1:0]    ques_cond;
   logic [NUM_SCPI-1:0][SCPI_W-1:0] cond_now;
   logic [NUM_SCPI-1:0][SCPI_W-1:0] scpi_rd;
   logic [NUM_SCPI-1:0]             scpi_hit;
   logic [NUM_SCPI-1:0]             summary;
   logic [ESR_W-1:0]     esr_q;
   logic [ESR_W-1:0]     ese_q;
   logic [STB_W-1:0]     sre_q;
   logic [STB_W-1:0]     stb;
   logic                 errq_empty;
   logic                 esr_read;
   logic                 flush_pending_q;
   logic                 line_start_q;
   logic [SCPI_W-1:0]    rd_d;

   // pins reach logic only after two flops
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_meta_q  <= '0;
         pin_q       <= '0;
         oper_meta_q <= SCPI_ZERO;
         oper_q      <= SCPI_ZERO;
      end else begin
         pin_meta_q  <= {loop_lock_lost, low_amplitude_flag, margin_exceeded, limit_exceeded,
                         uncalibrated_flag, generator_overload, converter_clipping,
                         temperature_fault, channel_overload, probe_overload,
                         probe_supply_overload};
         pin_q       <= pin_meta_q;
         oper_meta_q <= oper_cond_in;
         oper_q      <= oper_meta_q;
      end
   end

   always_comb begin
      ques_cond = SCPI_ZERO;
      ques_cond[QB_PROBE_SUPPLY] = pin_q[0];
      ques_cond[QB_PROBE]        = pin_q[1];
      ques_cond[QB_CHANNEL]      = pin_q[2];
      ques_cond[QB_TEMP]         = pin_q[3];
      ques_cond[QB_CONVERTER]    = pin_q[4];
      ques_cond[QB_GENERATOR]    = pin_q[5];
      ques_cond[QB_UNCAL]        = pin_q[6];
      ques_cond[QB_LIMIT]        = pin_q[7];
      ques_cond[QB_MARGIN]       = pin_q[8] & ~pin_q[7];
      ques_cond[QB_LOW_AMPL]     = pin_q[9];
      ques_cond[QB_LOOP_LOCK]    = pin_q[10];
   end

   assign cond_now[REG_OPER] = oper_q;
   assign cond_now[REG_QUES] = ques_cond;

   for (genvar r = 0; r < NUM_SCPI; r++) begin : g_reg
      localparam logic [SEL_W-1:0] BASE = SEL_W'(r * SEL_FIELDS);
      logic [SCPI_W-1:0] prev_q;
      logic [SCPI_W-1:0] event_q;
      logic [SCPI_W-1:0] enable_q;
      logic [SCPI_W-1:0] ptr_q;
      logic [SCPI_W-1:0] ntr_q;
      logic [SCPI_W-1:0] trans;
      logic              ev_clear;
      logic              wr_hit;

      assign trans    = (cond_now[r] & ~prev_q & ptr_q) | (~cond_now[r] & prev_q & ntr_q);
      assign ev_clear = cmd_clear_status | (rd_en && reg_sel == BASE + SEL_W'(F_EVENT));
      assign wr_hit   = wr_en && reg_sel >= BASE && reg_sel < BASE + SEL_W'(SEL_FIELDS);

      always_ff @(posedge clk) begin
         if (rst) begin
            prev_q  <= SCPI_ZERO;
            event_q <= SCPI_ZERO;
         end else begin
            prev_q  <= cond_now[r];
            event_q <= (ev_clear ? SCPI_ZERO : event_q) | trans;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            enable_q <= SCPI_ZERO;
            ptr_q    <= SCPI_ONES;
            ntr_q    <= SCPI_ZERO;
         end else if (cmd_status_preset) begin
            enable_q <= SCPI_ZERO;
            ptr_q    <= SCPI_ONES;
            ntr_q    <= SCPI_ZERO;
         end else if (wr_hit) begin
            if (reg_sel == BASE + SEL_W'(F_ENABLE)) begin
               enable_q <= wr_data;
            end
            if (reg_sel == BASE + SEL_W'(F_PTR)) begin
               ptr_q <= wr_data;
            end
            if (reg_sel == BASE + SEL_W'(F_NTR)) begin
               ntr_q <= wr_data;
            end
         end
      end

      assign summary[r] = |(event_q & enable_q);

      always_comb begin
         scpi_hit[r] = 1'b1;
         case (reg_sel - BASE)
            SEL_W'(F_COND):   scpi_rd[r] = cond_now[r];
            SEL_W'(F_EVENT):  scpi_rd[r] = event_q;
            SEL_W'(F_ENABLE): scpi_rd[r] = enable_q;
            SEL_W'(F_PTR):    scpi_rd[r] = ptr_q;
            SEL_W'(F_NTR):    scpi_rd[r] = ntr_q;
            default: begin
               scpi_rd[r]  = SCPI_ZERO;
               scpi_hit[r] = 1'b0;
            end
         endcase
      end

      a_event_latch: assert property (@(posedge clk) disable iff (rst)
         (cond_now[r] & ~prev_q & ptr_q) != SCPI_ZERO |=> (event_q & $past(trans)) == $past(trans))
         else $error("filtered rising edge did not latch an event");
   end

   // event status register, destructive read
   assign esr_read = rd_en && reg_sel == SEL_ESR;

   always_ff @(posedge clk) begin
      if (rst) begin
         esr_q <= ESR_RESET;
      end else begin
         // cleared by clear status, new events still land
         esr_q <= ((cmd_clear_status || esr_read) ? BYTE_ZERO : esr_q) | esr_event_set;
      end
   end

   // masks survive clear status and status preset
   always_ff @(posedge clk) begin
      if (rst) begin
         ese_q <= BYTE_ZERO;
         sre_q <= BYTE_ZERO;
      end else if (wr_en) begin
         if (reg_sel == SEL_ESE) begin
            ese_q <= wr_data[ESR_W-1:0];
         end
         if (reg_sel == SEL_SRE) begin
            sre_q <= wr_data[STB_W-1:0];
         end
      end
   end

   always_comb begin
      stb           = BYTE_ZERO;
      stb[STB_ERRQ] = ~errq_empty;
      stb[STB_QUES] = summary[REG_QUES];
      stb[STB_MAV]  = out_buf_avail;
      stb[STB_ESB]  = |(esr_q & ese_q);
      stb[STB_RQS]  = srq_q;
      stb[STB_OPER] = summary[REG_OPER];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         srq_q <= 1'b0;
      end else begin
         srq_q <= |(stb & sre_q & STB_SRQ_MASK);
      end
   end

   qss_err_queue #(
      .WIDTH (ERR_W),
      .DEPTH (ERR_DEPTH)
   ) u_err_queue (
      .clk          (clk),
      .rst          (rst),
      .clear        (cmd_clear_status),
      .push         (err_push),
      .push_data    (err_code),
      .pop          (err_pop),
      .dout_q       (err_rd_code_q),
      .dout_valid_q (err_rd_valid_q),
      .empty        (errq_empty),
      .full         ()
   );

   // value is the binary weight sum
   always_comb begin
      rd_d = SCPI_ZERO;
      if (scpi_hit[REG_OPER]) begin
         rd_d = scpi_rd[REG_OPER];
      end else if (scpi_hit[REG_QUES]) begin
         rd_d = scpi_rd[REG_QUES];
      end else if (reg_sel == SEL_ESR) begin
         rd_d = {8'h00, esr_q};
      end else if (reg_sel == SEL_ESE) begin
         rd_d = {8'h00, ese_q};
      end else if (reg_sel == SEL_SRE) begin
         rd_d = {8'h00, sre_q};
      end else if (reg_sel == SEL_STB) begin
         rd_d = {8'h00, stb};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q  <= SCPI_ZERO;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_en;
         if (rd_en) begin
            rd_data_q <= rd_d;
         end
      end
   end

   // line tracking for the deferred output flush
   always_ff @(posedge clk) begin
      if (rst) begin
         line_start_q    <= 1'b1;
         flush_pending_q <= 1'b0;
      end else begin
         if (msg_terminator) begin
            line_start_q <= 1'b1;
         end else if (cmd_start) begin
            line_start_q <= 1'b0;
         end
         if (cmd_reset || cmd_status_preset || cmd_clear_status) begin
            flush_pending_q <= 1'b1;
         end else if (cmd_start && line_start_q) begin
            flush_pending_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flush_out_q      <= 1'b0;
         flush_in_q       <= 1'b0;
         abort_cmd_q      <= 1'b0;
         settings_reset_q <= 1'b0;
      end else begin
         flush_out_q      <= cmd_device_clear | (flush_pending_q & line_start_q & cmd_start);
         flush_in_q       <= cmd_device_clear;
         abort_cmd_q      <= cmd_device_clear;
         settings_reset_q <= cmd_reset;
      end
   end

   // checked against the raw pins two edges back, so the synchroniser is covered too
   a_margin_excl: assert property (@(posedge clk) disable iff (rst)
      (!$past(rst, 1) && !$past(rst, 2)) |->
         ques_cond[QB_MARGIN] == ($past(margin_exceeded, 2) && !$past(limit_exceeded, 2)))
      else $error("margin bit does not follow margin without limit");

   a_srq_cause: assert property (@(posedge clk) disable iff (rst)
      srq_q |-> $past(|(stb & sre_q & STB_SRQ_MASK)))
      else $error("service request without enabled cause");

   a_esb_position: assert property (@(posedge clk) disable iff (rst)
      stb[STB_ESB] == |(esr_q & ese_q) && stb[STB_QUES] == summary[REG_QUES])
      else $error("summary bits misplaced in status byte");

   a_cls_masks: assert property (@(posedge clk) disable iff (rst)
      (cmd_clear_status && !wr_en && esr_event_set == BYTE_ZERO) |=>
         esr_q == BYTE_ZERO && $stable(sre_q) && $stable(ese_q) && errq_empty)
      else $error("clear status result wrong");

   a_preset_enable: assert property (@(posedge clk) disable iff (rst)
      cmd_status_preset |=> g_reg[REG_QUES].enable_q == SCPI_ZERO
         && g_reg[REG_OPER].enable_q == SCPI_ZERO)
      else $error("status preset left an enable set");

   a_preset_filter: assert property (@(posedge clk) disable iff (rst)
      cmd_status_preset |=> g_reg[REG_QUES].ptr_q == SCPI_ONES
         && g_reg[REG_QUES].ntr_q == SCPI_ZERO && g_reg[REG_OPER].ptr_q == SCPI_ONES)
      else $error("status preset filters wrong");

   a_dcl_buffers: assert property (@(posedge clk) disable iff (rst)
      (cmd_device_clear && !cmd_clear_status && !esr_read && esr_event_set == BYTE_ZERO)
         |=> flush_out_q && flush_in_q && abort_cmd_q && $stable(esr_q))
      else $error("device clear actions wrong");

   a_deferred_flush: assert property (@(posedge clk) disable iff (rst)
      (flush_pending_q && line_start_q && cmd_start) |=> flush_out_q
         && (!flush_pending_q || $past(cmd_reset || cmd_status_preset || cmd_clear_status)))
      else $error("deferred output flush missing");

   a_settings_only: assert property (@(posedge clk) disable iff (rst)
      settings_reset_q |-> $past(cmd_reset))
      else $error("settings reset without reset command");

endmodule

// File: dv/qss_ctrl_model.sv
// qss_ctrl_model: remote controller side, register reads and writes
// assumes: drives after the falling edge, the block samples on the rising edge
`timescale 1ns/1ps
module qss_ctrl_model import qss_pkg::*; (
   // clock and read answer
   input  wire logic              clk,
   input  wire logic              rd_valid_q,
   input  wire logic [SCPI_W-1:0] rd_data_q,
   // requests
   output logic      [SEL_W-1:0]  reg_sel,
   output logic                   wr_en,
   output logic      [SCPI_W-1:0] wr_data,
   output logic                   rd_en
);
   initial begin
      reg_sel = 4'h0;
      wr_en   = 1'b0;
      wr_data = 16'h0000;
      rd_en   = 1'b0;
   end

   task automatic wr(input logic [3:0] s, input logic [15:0] d);
      @(negedge clk);
      reg_sel = s;
      wr_data = d;
      wr_en   = 1'b1;
      @(negedge clk);
      wr_en   = 1'b0;
   endtask

   // no ready on this port: wait a bounded while for the answer strobe
   task automatic rd(input logic [3:0] s, output logic [15:0] d);
      int i;
      @(negedge clk);
      reg_sel = s;
      rd_en   = 1'b1;
      @(negedge clk);
      rd_en   = 1'b0;
      for (i = 0; i < 3 && rd_valid_q !== 1'b1; i++) @(negedge clk);
      d = rd_data_q;
   endtask
endmodule

// File: dv/questionable_status_srq_logic_tb.sv
// questionable_status_srq_logic_tb: self-checking bench of the status core
// assumes: qss_ctrl_model does register access; inputs change on the falling edge
`timescale 1ns/1ps
module questionable_status_srq_logic_tb import qss_pkg::*;;
   logic clk, rst, out_buf_avail, err_push, err_pop, err_rd_valid_q, rd_en, wr_en, rd_valid_q;
   logic cmd_device_clear, cmd_reset, cmd_status_preset, cmd_clear_status;
   logic msg_terminator, cmd_start, srq_q, flush_out_q, flush_in_q, abort_cmd_q, settings_reset_q;
   logic [10:0] pins;
   logic [15:0] oper_cond_in, err_code, err_rd_code_q, wr_data, rd_data_q, d;
   logic [7:0]  esr_event_set;
   logic [3:0]  reg_sel;
   int fail_count, num_checks, n_fo, n_fi, n_ab, n_sr, k;
   int qbit[11] = '{QB_PROBE_SUPPLY, QB_PROBE, QB_CHANNEL, QB_TEMP, QB_CONVERTER,
      QB_GENERATOR, QB_UNCAL, QB_LIMIT, QB_MARGIN, QB_LOW_AMPL, QB_LOOP_LOCK};

   qss_status_core DUT (.clk(clk), .rst(rst), .probe_supply_overload(pins[0]),
      .probe_overload(pins[1]), .channel_overload(pins[2]), .temperature_fault(pins[3]),
      .converter_clipping(pins[4]), .generator_overload(pins[5]),
      .uncalibrated_flag(pins[6]), .limit_exceeded(pins[7]), .margin_exceeded(pins[8]),
      .low_amplitude_flag(pins[9]), .loop_lock_lost(pins[10]), .oper_cond_in(oper_cond_in),
      .esr_event_set(esr_event_set), .out_buf_avail(out_buf_avail), .err_push(err_push),
      .err_code(err_code), .err_pop(err_pop), .err_rd_code_q(err_rd_code_q),
      .err_rd_valid_q(err_rd_valid_q), .reg_sel(reg_sel), .wr_en(wr_en), .wr_data(wr_data),
      .rd_en(rd_en), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
      .cmd_device_clear(cmd_device_clear), .cmd_reset(cmd_reset),
      .cmd_status_preset(cmd_status_preset), .cmd_clear_status(cmd_clear_status),
      .msg_terminator(msg_terminator), .cmd_start(cmd_start), .srq_q(srq_q),
      .flush_out_q(flush_out_q), .flush_in_q(flush_in_q), .abort_cmd_q(abort_cmd_q),
      .settings_reset_q(settings_reset_q));
   qss_ctrl_model ctrl (.clk(clk), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
      .reg_sel(reg_sel), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // output pulses are one cycle wide, so count them on every rising edge
   always @(posedge clk) begin
      n_fo += (flush_out_q === 1'b1);
      n_fi += (flush_in_q === 1'b1);
      n_ab += (abort_cmd_q === 1'b1);
      n_sr += (settings_reset_q === 1'b1);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic pop(input logic [15:0] exp);
      int i;
      pulse(err_pop);
      for (i = 0; i < 3 && err_rd_valid_q !== 1'b1; i++) @(negedge clk);
      check(err_rd_code_q, exp);
   endtask
   task automatic rdc(input logic [3:0] s, input logic [15:0] exp);
      ctrl.rd(s, d);
      check(d, exp);
   endtask

   task automatic t_reset;
      rdc(SEL_ESR, 16'h0080);
      rdc(4'h7, 16'h0000);
      rdc(4'h8, 16'hFFFF);
      rdc(4'h9, 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_cond;
      for (k = 0; k < 11; k++) begin
         pins = 11'h001 << k;
         idle(4);
         rdc(4'h5, 16'h0001 << qbit[k]);
      end
      pins = 11'h180;
      idle(4);
      rdc(4'h5, 16'h0200);
      pins = 11'h000;
      idle(4);
      rdc(4'h6, 16'h2F7E);
      rdc(4'h6, 16'h0000);
      $display("test cond done");
   endtask

   task automatic t_srq;
      ctrl.wr(4'h7, 16'hFFFF);
      ctrl.wr(SEL_SRE, 16'h0008);
      pins[1] = 1'b1;
      idle(6);
      check(srq_q, 1'b1);
      rdc(SEL_STB, 16'h0048);
      rdc(4'h6, 16'h0004);
      idle(4);
      check(srq_q, 1'b0);
      pins[1] = 1'b0;
      idle(4);
      rdc(4'h6, 16'h0000);
      $display("test srq done");
   endtask

   task automatic t_clear;
      esr_event_set = 8'h20;
      idle(1);
      esr_event_set = 8'h00;
      ctrl.wr(SEL_ESE, 16'h0020);
      err_code = 16'h0105;
      pulse(err_push);
      idle(3);
      rdc(SEL_STB, 16'h0024);
      // clear status comes inside a line, so the line has already started
      pulse(cmd_start);
      k = n_fo;
      pulse(cmd_clear_status);
      idle(2);
      rdc(SEL_ESR, 16'h0000);
      rdc(SEL_STB, 16'h0000);
      rdc(SEL_ESE, 16'h0020);
      rdc(4'h7, 16'hFFFF);
      pulse(cmd_start);
      idle(2);
      check(n_fo - k, 16'h0000);
      pulse(msg_terminator);
      pulse(cmd_start);
      idle(2);
      check(n_fo - k, 16'h0001);
      $display("test clear done");
   endtask

   task automatic t_preset;
      ctrl.wr(4'h9, 16'h00FF);
      ctrl.wr(4'h8, 16'h0000);
      pulse(cmd_status_preset);
      idle(2);
      rdc(4'h7, 16'h0000);
      rdc(4'h8, 16'hFFFF);
      rdc(4'h9, 16'h0000);
      rdc(SEL_SRE, 16'h0008);
      $display("test preset done");
   endtask

   task automatic t_dcl;
      ctrl.wr(SEL_ESE, 16'h0011);
      k = n_fo + n_fi + n_ab;
      pulse(cmd_device_clear);
      idle(2);
      check(n_fo + n_fi + n_ab - k, 16'h0003);
      check(n_sr, 16'h0000);
      rdc(SEL_ESE, 16'h0011);
      pulse(cmd_reset);
      idle(2);
      check(n_sr, 16'h0001);
      k = n_fo;
      pulse(msg_terminator);
      pulse(cmd_start);
      idle(2);
      check(n_fo - k, 16'h0001);
      $display("test device clear done");
   endtask

   task automatic t_oper;
      ctrl.wr(4'h2, 16'h0010);
      ctrl.wr(SEL_SRE, 16'h0090);
      oper_cond_in  = 16'h0010;
      out_buf_avail = 1'b1;
      idle(6);
      check(srq_q, 1'b1);
      rdc(4'h0, 16'h0010);
      rdc(SEL_STB, 16'h00D0);
      rdc(4'h1, 16'h0010);
      idle(2);
      rdc(SEL_STB, 16'h0050);
      out_buf_avail = 1'b0;
      oper_cond_in  = 16'h0000;
      idle(4);
      check(srq_q, 1'b0);
      rdc(4'h1, 16'h0000);
      $display("test operation done");
   endtask

   task automatic t_errq;
      @(negedge clk);
      err_push = 1'b1;
      for (k = 0; k < 9; k++) begin
         err_code = 16'hA000 + 16'(k);
         @(negedge clk);
      end
      err_push = 1'b0;
      for (k = 0; k < 9; k++) pop(k < 8 ? 16'hA000 + 16'(k) : 16'h0000);
      $display("test error queue done");
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      {rst, pins, oper_cond_in, esr_event_set, out_buf_avail} = '0;
      {err_push, err_code, err_pop, cmd_device_clear, cmd_reset} = '0;
      {cmd_status_preset, cmd_clear_status, msg_terminator, cmd_start} = '0;
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_cond;
      t_srq;
      t_clear;
      t_preset;
      t_dcl;
      t_oper;
      t_errq;
      stop_test;
   end

   // whole run takes well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      stop_test;
   end
endmodule
